// [logic/wgc_regs.vh]
// Register map, field positions and reset values of the waveform control block
`ifndef WGC_REGS_VH
`define WGC_REGS_VH

`define WGC_ADDR_W          4
`define WGC_CTRL0_OFFSET    4'h0
`define WGC_STATUS_OFFSET   4'h1
`define WGC_CTRL0_RESET     8'h00
`define WGC_ENABLE_BIT      7
`define WGC_LOAD_BIT        6
`define WGC_MODE_MSB        2
`define WGC_MODE_LSB        0
`define WGC_MODE_ASYNC_STEER 3'h0
`define WGC_MODE_SYNC_STEER  3'h1
`define WGC_MODE_FWD_BRIDGE  3'h2
`define WGC_MODE_REV_BRIDGE  3'h3
`define WGC_MODE_HALF_BRIDGE 3'h4
`define WGC_MODE_PUSH_PULL   3'h5

`endif

// [logic/wgc_control.v]
// Control register front end of the complementary waveform unit
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "wgc_regs.vh"

// Functional notes
// R1 - Enable bit 7 turns the waveform module on; clear holds it disabled.
// R2 - Load request loads buffers on first rising data edge after a falling edge.
// R3 - With load request clear, buffers keep their values; no transfer occurs.
// R4 - Hardware clears the load request bit itself.
// R5 - Load request sets only when enable already 1; joint write leaves it clear.
// R6 - Mode field: 000..101 select steering, bridge, half-bridge, push-pull modes.
// R7 - Software must not program reserved mode codes 110 and 111.
// R8 - Bits 5 to 3 read as zero and ignore writes.
// R9 - Enable, load request and mode reset to zero on every reset.
// R10 - Load request clears in the same cycle the buffer transfer completes.
module wgc_control (
    // Clock and reset
    input  wire         mclk,
    input  wire         resetn,
    // Register port
    input  wire [3:0]   reg_addr,
    input  wire [7:0]   reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [7:0]   reg_rdata,
    // Waveform input data, asynchronous
    input  wire         wave_in,
    // To waveform logic
    output reg          module_enable,
    output reg  [2:0]   mode,
    output reg          buffer_load,
    output reg  [5:0]   mode_onehot,
    output reg          mode_reserved
);

    // One-hot states of the load tracker
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_FALL = 3'b010;
    localparam [2:0] ST_RISE = 3'b100;

    reg        wave_s1;
    reg        wave_s2;
    reg        wave_d;
    reg        load_request;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg        next_load;
    reg        load_fire;
    reg  [7:0] next_rdata;

    // Address compare shared by the write and read decoders
    function addr_hit;
        input [3:0] addr;
        input [3:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Control register readback; unimplemented bits 5:3 return zero
    function [7:0] ctrl_image;
        input       en;
        input       ld;
        input [2:0] m;
        begin
            ctrl_image = {en, ld, 3'h0, m};
        end
    endfunction

    wire ctrl_wr = reg_wr && addr_hit(reg_addr, `WGC_CTRL0_OFFSET);
    wire fall    = wave_d && !wave_s2;
    wire rise    = !wave_d && wave_s2;

    function [5:0] decode_mode;
        input [2:0] m;
        begin
            decode_mode = 6'h00;
            if (m <= `WGC_MODE_PUSH_PULL) begin
                decode_mode[m] = 1'b1;
            end
        end
    endfunction

    // Two-stage synchroniser for the asynchronous data input
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wave_s1 <= 1'b0;
            wave_s2 <= 1'b0;
        end else begin
            wave_s1 <= wave_in;
            wave_s2 <= wave_s1;
        end
    end

    // Delayed copy of the synchronised input for edge detection
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wave_d <= 1'b0;
        end else begin
            wave_d <= wave_s2;
        end
    end

    // Edge tracking for a pending load
    always @* begin
        next_state = state;
        load_fire  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (load_request) begin
                    next_state = ST_FALL; // R2
                end
            end
            ST_FALL: begin
                if (!load_request) begin
                    next_state = ST_IDLE;
                end else if (fall) begin
                    next_state = ST_RISE; // R2
                end
            end
            ST_RISE: begin
                if (!load_request) begin
                    next_state = ST_IDLE;
                end else if (rise) begin
                    load_fire  = 1'b1; // R2
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Load request: set by software only when already enabled
    always @* begin
        next_load = load_request;
        if (load_fire) begin
            next_load = 1'b0; // R4 R10
        end
        if (ctrl_wr) begin
            if (!reg_wdata[`WGC_ENABLE_BIT]) begin
                next_load = 1'b0;
            end else if (reg_wdata[`WGC_LOAD_BIT] && module_enable) begin
                next_load = 1'b1; // R5
            end
        end
    end

    // Enable and mode fields
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            module_enable <= 1'b0; // R9
            mode          <= 3'h0; // R9
        end else if (ctrl_wr) begin
            module_enable <= reg_wdata[`WGC_ENABLE_BIT]; // R1
            mode <= reg_wdata[`WGC_MODE_MSB:`WGC_MODE_LSB]; // R6
        end
    end

    // Load request flag and its edge tracker
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_request <= 1'b0; // R9
            state        <= ST_IDLE;
        end else begin
            load_request <= next_load; // R4
            state        <= next_state;
        end
    end

    // Buffer transfer strobe, one cycle per completed edge pair
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            buffer_load <= 1'b0;
        end else begin
            buffer_load <= load_fire; // R2 R3
        end
    end

    // Registered mode decode; lags the mode field by one cycle
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_onehot   <= 6'h01;
            mode_reserved <= 1'b0;
        end else begin
            mode_onehot   <= decode_mode(mode); // R6
            mode_reserved <= (mode > `WGC_MODE_PUSH_PULL); // R7
        end
    end

    // Read data select; zero whenever no read is under way
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (addr_hit(reg_addr, `WGC_CTRL0_OFFSET)) begin
                next_rdata = ctrl_image(module_enable, load_request,
                                        mode); // R8
            end else if (addr_hit(reg_addr, `WGC_STATUS_OFFSET)) begin
                next_rdata = {5'h00, state};
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // Read data register
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// [dv/wgc_control_monitor.sv]
// Checker for the waveform control front end
`timescale 1ns/1ps
module wgc_mon (input logic mclk, resetn, reg_wr, reg_rd, buffer_load,
    module_enable, mode_reserved, input logic [3:0] reg_addr,
    input logic [2:0] mode, input logic [5:0] mode_onehot,
    input logic [7:0] reg_wdata, reg_rdata);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire w = reg_wr && reg_addr == 4'h0;
    wire r = reg_rd && reg_addr == 4'h0;
    AST_EN: assert property (w |=> module_enable == $past(reg_wdata[7]))
        else $error("en");
    AST_MODE: assert property (w |=> mode == $past(reg_wdata[2:0]))
        else $error("mode");
    AST_HOT: assert property (mode < 3'h6 |=>
        mode_onehot == 6'h01 << $past(mode)) else $error("hot");
    AST_RSV: assert property (mode > 3'h5 |=>
        mode_reserved && mode_onehot == 6'h00) else $error("rsv");
    AST_JOIN: assert property (w && reg_wdata[6] && !module_enable
        |=> !buffer_load [*3]) else $error("join");
    AST_PULSE: assert property (buffer_load |=> !buffer_load)
        else $error("pulse");
    AST_ZERO: assert property (reg_rd |=> reg_rdata[5:3] == 3'h0)
        else $error("zero");
    AST_RD: assert property (r |=> reg_rdata[7] == module_enable
        && reg_rdata[2:0] == mode) else $error("rd");
    COV_LD: cover property (buffer_load);
    COV_RSV: cover property (mode_reserved);
    COV_RD: cover property (r);
endmodule
bind wgc_control wgc_mon i_wgc_mon (.*);

// [dv/testbench.sv]
// Bench for the waveform control front end
`timescale 1ns/1ps
module testbench;
    logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, wave_in = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [5:0] mode_onehot;
    logic [2:0] mode;
    logic module_enable, buffer_load, mode_reserved;
    int err_count = 0, tests_run = 0, i, n = 0;
    wgc_control i_wgc_control (.*);
    initial forever #2.5 mclk = ~mclk;
    // Load pulses are counted off the sampling edge
    always @(negedge mclk) n += (buffer_load === 1'b1);
    task wrap_up; $display("%0d checks %0d errors", tests_run, err_count);
        if (!err_count && tests_run) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish; endtask
    initial begin #3000; err_count++; wrap_up; end
    task chk(string s, logic [7:0] v, e); tests_run++;
        if (v !== e) $display("CHECK FAILED %s exp %h seen %h", s, e, v);
        err_count += (v !== e); endtask
    task acc(logic r, logic [7:0] d, logic [3:0] a = 4'h0);
        reg_addr <= a; reg_wdata <= d; reg_rd <= r; reg_wr <= !r;
        @(posedge mclk) {reg_rd, reg_wr} <= 2'h0;
        @(negedge mclk) if (r) chk("rdata", reg_rdata, d);
        @(posedge mclk); endtask
    task rst; resetn <= 0; repeat (10) @(posedge mclk);
        resetn <= 1; @(posedge mclk); endtask
    task wave(logic v, logic [7:0] e); wave_in <= v;
        repeat (12) @(posedge mclk); chk("loads", n[7:0], e); endtask
    initial begin
        rst; acc(1, 8'h00);
        for (i = 0; i < 8; i++) begin
            acc(0, 8'h38 | i[7:0]); acc(1, i[7:0]);
            chk("dec", {1'h0, mode_reserved, mode_onehot},
                i < 6 ? 8'h01 << i : 8'h40);
        end
        $display("modes done");
        acc(0, 8'hC5); acc(1, 8'h85);
        acc(0, 8'hC5); acc(1, 8'hC5);
        acc(1, 8'h02, 4'h1);
        wave(1, 0); wave(0, 0); wave(1, 1);
        acc(1, 8'h85);
        chk("en", {7'h0, module_enable}, 8'h01);
        rst; acc(1, 8'h00);
        $display("load done");
        wrap_up;
    end
endmodule
